//--- hw/fphc_defines.vh
// constants shared by the flash protect, power and pause control block
`ifndef FPHC_DEFINES_VH
`define FPHC_DEFINES_VH

// instruction codes seen in the first byte after select falls
`define FPHC_OP_WRITE_ENABLE 8'h06
`define FPHC_OP_WRITE_DISABLE 8'h04
`define FPHC_OP_READ_STATUS 8'h05
`define FPHC_OP_STATUS_WRITE 8'h01
`define FPHC_OP_PAGE_WRITE 8'h02
`define FPHC_OP_BLOCK_CLEAR 8'hD8
`define FPHC_OP_WHOLE_ERASE 8'hC7
`define FPHC_OP_DEEP_SLEEP 8'hB9
`define FPHC_OP_WAKE_AND_ID 8'hAB

// status word field positions
`define FPHC_ST_BUSY 0
`define FPHC_ST_LATCH 1
`define FPHC_ST_LEVEL_LO 2
`define FPHC_ST_LEVEL_HI 4
`define FPHC_ST_LOCK 7

// reset values (power-up state of the status bits)
`define FPHC_RST_LEVEL 3'h0
`define FPHC_RST_LOCK 1'h0

// power mode encoding on power_mode
`define FPHC_PM_STANDBY 2'h0
`define FPHC_PM_ACTIVE 2'h1
`define FPHC_PM_DEEP 2'h2

// internal cycle kinds on array_kind
`define FPHC_KIND_STATUS 2'h0
`define FPHC_KIND_PAGE 2'h1
`define FPHC_KIND_SECTOR 2'h2
`define FPHC_KIND_BULK 2'h3

// byte counts each modifying instruction must carry
`define FPHC_BYTES_SHORT 4'h1
`define FPHC_BYTES_STATUS 4'h2
`define FPHC_BYTES_SECTOR 4'h4
`define FPHC_BYTES_PAGE_MIN 4'h5

// sync stage reset pattern: {guard_n, pause_n, din, sclk, select_n}
`define FPHC_PIN_IDLE 5'h19

`endif

//--- hw/fphc_flash_protect_ctrl.v
// power mode, status word, write protection and pause control
`include "fphc_defines.vh"
`default_nettype none

// Overview of operation
// RULE_01: select low means enabled and active
// RULE_02: stay active until internal cycle ends
// RULE_03: deep sleep holds until wake command
// RULE_04: deep sleep ignores all but wake
// RULE_05: status word carries busy flag
// RULE_06: status word mirrors write latch
// RULE_07: protect level selects protected region size
// RULE_08: lock plus guard pin freezes status bits
// RULE_09: modifying commands need whole byte counts
// RULE_10: modifying commands need write latch set first
// RULE_11: latch cleared at reset and completions
// RULE_12: decode protect level into sector range
// RULE_13: pause keeps bit count, internal cycle continues
// RULE_14: pause begins when clock is low
// RULE_15: pause ends when clock is low
// RULE_16: paused: output released, inputs ignored
// RULE_17: master keeps select low while paused
// RULE_18: select rising while paused resets interface
// RULE_19: master raises pause before reselecting
// RULE_20: write enable command sets write latch
// RULE_21: busy reads one only during cycles
// RULE_22: protected targets are never programmed or erased
module fphc_flash_protect_ctrl #(
  parameter STATUS_CYCLES = 16,
  parameter PAGE_CYCLES = 64,
  parameter SECTOR_CYCLES = 256,
  parameter BULK_CYCLES = 1024
) (
  input wire clk,
  input wire rst,
  input wire select_n,
  input wire sclk,
  input wire serial_in,
  input wire pause_n,
  input wire write_guard_n,
  output reg serial_out,
  output reg serial_out_oe,
  output reg [1:0] power_mode,
  output reg [7:0] status_word,
  output reg pause_active,
  output reg array_start,
  output reg [1:0] array_kind,
  output reg [18:0] array_addr
);

  // protected-sector test shared by page and sector requests
  function prot_hit;
    input [2:0] level;
    input [2:0] sector;
    begin
      prot_hit = level[2] ||
        (level == 3'h3 && sector >= 3'h4) ||
        (level == 3'h2 && sector >= 3'h6) ||
        (level == 3'h1 && sector == 3'h7); // RULE_12
    end
  endfunction

  wire [4:0] pins;
  wire sel_s = pins[0];
  wire sclk_s = pins[1];
  wire din_s = pins[2];
  wire pause_s = pins[3];
  wire guard_s = pins[4];

  fphc_sync3 #(.W(5), .INIT(`FPHC_PIN_IDLE)) u_sync (
    .clk(clk),
    .rst(rst),
    .async_in({write_guard_n, pause_n, serial_in, sclk, select_n}),
    .sync_out(pins)
  );

  reg sel_q;
  reg sclk_q;
  reg paused;
  reg [2:0] bit_cnt;
  reg [3:0] byte_cnt;
  reg [6:0] shift;
  reg [7:0] opcode;
  reg [7:0] b1;
  reg [7:0] b2;
  reg [7:0] b3;
  reg reading;
  reg [2:0] out_idx;
  reg deep;
  reg busy;
  reg [19:0] busy_cnt;
  reg [1:0] cur_kind;
  reg latch;
  reg lock;
  reg [2:0] level;
  reg [7:0] new_status;

  wire sclk_rise = sclk_s & ~sclk_q;
  wire sclk_fall = ~sclk_s & sclk_q;
  wire sel_rise = sel_s & ~sel_q;
  // paused state makes the serial clock and data a don't-care
  wire live = ~sel_s & ~paused; // RULE_16
  wire [7:0] in_byte = {shift, din_s};
  wire [18:0] addr = {b1[2:0], b2, b3};
  wire hw_locked = lock & ~guard_s; // RULE_08
  wire [7:0] st_now = {lock, 2'h0, level, latch, busy};
  // a finished frame only counts when no pause was pending at the rise
  wire frame_end = sel_rise & ~paused & (byte_cnt != 4'h0); // RULE_18
  wire whole = (bit_cnt == 3'h0); // RULE_09

  reg go;
  reg [1:0] go_kind;
  reg [19:0] go_cycles;

  // decide whether a finished frame launches an internal cycle
  always @* begin
    go = 1'b0;
    go_kind = `FPHC_KIND_STATUS;
    go_cycles = STATUS_CYCLES[19:0];
    // busy blocks new work; deep sleep blocks all but wake
    if (frame_end && whole && latch && !deep && !busy) begin // RULE_04 RULE_10
      if (opcode == `FPHC_OP_STATUS_WRITE &&
          byte_cnt == `FPHC_BYTES_STATUS && !hw_locked) begin // RULE_08
        go = 1'b1;
      end else if (opcode == `FPHC_OP_PAGE_WRITE &&
          byte_cnt >= `FPHC_BYTES_PAGE_MIN &&
          !prot_hit(level, addr[18:16])) begin // RULE_22
        go = 1'b1;
        go_kind = `FPHC_KIND_PAGE;
        go_cycles = PAGE_CYCLES[19:0];
      end else if (opcode == `FPHC_OP_BLOCK_CLEAR &&
          byte_cnt == `FPHC_BYTES_SECTOR &&
          !prot_hit(level, addr[18:16])) begin // RULE_22
        go = 1'b1;
        go_kind = `FPHC_KIND_SECTOR;
        go_cycles = SECTOR_CYCLES[19:0];
      end else if (opcode == `FPHC_OP_WHOLE_ERASE &&
          byte_cnt == `FPHC_BYTES_SHORT && level == 3'h0) begin // RULE_22
        go = 1'b1;
        go_kind = `FPHC_KIND_BULK;
        go_cycles = BULK_CYCLES[19:0];
      end
    end
  end

  // edge history of the filtered pins
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_q <= 1'b1;
      sclk_q <= 1'b0;
    end else begin
      sel_q <= sel_s;
      sclk_q <= sclk_s;
    end
  end

  // pause follows pause_n only while the serial clock is low, so a
  // pause edge during a high clock waits for the next low phase
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      paused <= 1'b0;
    end else if (sel_s) begin
      paused <= 1'b0; // RULE_18
    end else if (!sclk_s) begin
      paused <= ~pause_s; // RULE_14 RULE_15
    end
  end

  // bit and byte capture; counters survive a pause untouched
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_cnt <= 3'h0;
      byte_cnt <= 4'h0;
      shift <= 7'h00;
      opcode <= 8'h00;
      b1 <= 8'h00;
      b2 <= 8'h00;
      b3 <= 8'h00;
      reading <= 1'b0;
      out_idx <= 3'h0;
    end else if (sel_s) begin
      bit_cnt <= 3'h0; // interface restarts each frame
      byte_cnt <= 4'h0;
      reading <= 1'b0;
      out_idx <= 3'h0;
    end else if (live) begin // RULE_13
      if (sclk_rise) begin
        shift <= in_byte[6:0];
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == 3'h7) begin
          if (byte_cnt != 4'hF) begin
            byte_cnt <= byte_cnt + 4'h1; // saturates on long pages
          end
          if (byte_cnt == 4'h0) begin
            opcode <= in_byte;
            reading <= (in_byte == `FPHC_OP_READ_STATUS) & ~deep;
          end
          if (byte_cnt == 4'h1) begin
            b1 <= in_byte;
          end
          if (byte_cnt == 4'h2) begin
            b2 <= in_byte;
          end
          if (byte_cnt == 4'h3) begin
            b3 <= in_byte;
          end
        end
      end
      if (sclk_fall && reading) begin
        out_idx <= out_idx + 3'h1; // status repeats every byte
      end
    end
  end

  // deep power-down: entered by its command, left only by wake
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      deep <= 1'b0;
    end else if (frame_end) begin
      if (deep) begin
        if (opcode == `FPHC_OP_WAKE_AND_ID) begin
          deep <= 1'b0; // RULE_03
        end
      end else if (!busy && whole && byte_cnt == `FPHC_BYTES_SHORT &&
          opcode == `FPHC_OP_DEEP_SLEEP) begin
        deep <= 1'b1; // RULE_03
      end
    end
  end

  // internal cycle timer, write latch and non-volatile status bits
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      busy_cnt <= 20'h00000;
      cur_kind <= `FPHC_KIND_STATUS;
      latch <= 1'b0; // RULE_11
      lock <= `FPHC_RST_LOCK;
      level <= `FPHC_RST_LEVEL;
      new_status <= 8'h00;
      array_start <= 1'b0;
      array_kind <= `FPHC_KIND_STATUS;
      array_addr <= 19'h00000;
    end else begin
      array_start <= 1'b0;
      if (go) begin
        busy <= 1'b1; // RULE_05 RULE_21
        busy_cnt <= go_cycles - 20'h00001;
        cur_kind <= go_kind;
        new_status <= b1;
        array_start <= (go_kind != `FPHC_KIND_STATUS);
        array_kind <= go_kind;
        array_addr <= addr;
      end else if (busy) begin
        // a cycle in flight ignores pause and select entirely
        if (busy_cnt == 20'h00000) begin
          busy <= 1'b0; // RULE_21 RULE_13
          latch <= 1'b0; // RULE_11
          if (cur_kind == `FPHC_KIND_STATUS) begin
            lock <= new_status[`FPHC_ST_LOCK]; // RULE_07
            level <= new_status[`FPHC_ST_LEVEL_HI:`FPHC_ST_LEVEL_LO];
          end
        end else begin
          busy_cnt <= busy_cnt - 20'h00001;
        end
      end else if (frame_end && whole && !deep &&
          byte_cnt == `FPHC_BYTES_SHORT) begin
        if (opcode == `FPHC_OP_WRITE_ENABLE) begin
          latch <= 1'b1; // RULE_20 RULE_10
        end else if (opcode == `FPHC_OP_WRITE_DISABLE) begin
          latch <= 1'b0; // RULE_11
        end
      end
    end
  end

  // registered pin-facing outputs and observable state
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      serial_out <= 1'b0;
      serial_out_oe <= 1'b0;
      power_mode <= `FPHC_PM_STANDBY;
      status_word <= 8'h00;
      pause_active <= 1'b0;
    end else begin
      if (live && sclk_fall && reading) begin
        serial_out <= st_now[3'h7 - out_idx]; // RULE_05 RULE_06
      end
      // released while deselected or paused
      serial_out_oe <= live & reading; // RULE_16
      if (deep) begin
        power_mode <= `FPHC_PM_DEEP; // RULE_03
      end else if (!sel_s || busy || go) begin
        power_mode <= `FPHC_PM_ACTIVE; // RULE_01 RULE_02
      end else begin
        power_mode <= `FPHC_PM_STANDBY;
      end
      status_word <= st_now; // RULE_06
      pause_active <= paused;
    end
  end

endmodule // fphc_flash_protect_ctrl

`default_nettype wire

//--- hw/fphc_sync3.v
// three-stage pin synchroniser with a two-stage agreement filter
`default_nettype none

module fphc_sync3 #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire clk,
  input wire rst,
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);

  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;

  // s1 is only read by s2; output moves once s2 and s3 agree
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
      sync_out <= INIT;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      sync_out <= (s3 & ~(s2 ^ s3)) | (sync_out & (s2 ^ s3));
    end
  end

endmodule // fphc_sync3

`default_nettype wire

//--- verification/fphc_ctrl_asserts.sv
// port assertions for the flash protect control block
`default_nettype none
module fphc_ctrl_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic select_n,
  input wire logic sclk,
  input wire logic pause_n,
  input wire logic serial_out_oe,
  input wire logic [1:0] power_mode,
  input wire logic [7:0] status_word,
  input wire logic pause_active,
  input wire logic array_start,
  input wire logic [1:0] array_kind,
  input wire logic [18:0] array_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire [2:0] lv = status_word[4:2];
  wire [2:0] sc = array_addr[18:16];
  // bulk needs a clear level; page and sector look at the start sector
  wire hit = (array_kind == 2'h3) ? (lv != 3'h0) : (lv[2] ||
    (lv == 3'h1 && sc == 3'h7) || (lv == 3'h2 && sc[2:1] == 2'h3) ||
    (lv == 3'h3 && sc[2]));
  sequence s_desel; select_n [*8]; endsequence
  sequence s_sel; !select_n [*8]; endsequence
  property p_sel_act; s_sel ##0 power_mode != 2'h2 |-> power_mode == 2'h1;
  endproperty
  property p_idle; (select_n && !status_word[0]) [*8] |-> power_mode != 2'h1;
  endproperty
  property p_deep; s_desel ##0 power_mode == 2'h2 |=> power_mode == 2'h2;
  endproperty
  property p_busy; array_start |-> ##[0:3] status_word[0]; endproperty
  property p_latch; array_start |-> status_word[1]; endproperty
  property p_safe; array_start |-> !hit; endproperty
  property p_pon; (!pause_n && !select_n && !sclk) [*8] |-> pause_active;
  endproperty
  property p_poff; (pause_n && !sclk) [*8] |-> !pause_active; endproperty
  property p_poe; pause_active [*2] |-> !serial_out_oe; endproperty
  property p_psel; s_desel |-> !pause_active; endproperty
  // deep sleep never overlaps a cycle, so busy must mean active
  property p_busy_act; status_word[0] |-> power_mode == 2'h1; endproperty
  a_sel_act: assert property (p_sel_act)
    else $error("not active while selected");
  a_idle: assert property (p_idle)
    else $error("active while idle and deselected");
  a_deep: assert property (p_deep)
    else $error("deep sleep left without a frame");
  a_busy: assert property (p_busy)
    else $error("launch without busy");
  a_latch: assert property (p_latch)
    else $error("launch without write latch");
  a_safe: assert property (p_safe)
    else $error("launch into protected region");
  a_pon: assert property (p_pon)
    else $error("pause not entered");
  a_poff: assert property (p_poff)
    else $error("pause not left");
  a_poe: assert property (p_poe)
    else $error("output driven while paused");
  a_psel: assert property (p_psel)
    else $error("pause kept while deselected");
  a_busy_act: assert property (p_busy_act)
    else $error("not active while an internal cycle runs");
endmodule // fphc_ctrl_asserts

bind fphc_flash_protect_ctrl fphc_ctrl_asserts fphc_ctrl_asserts_i (
  .clk(clk), .rst(rst), .select_n(select_n), .sclk(sclk),
  .pause_n(pause_n), .serial_out_oe(serial_out_oe),
  .power_mode(power_mode), .status_word(status_word),
  .pause_active(pause_active), .array_start(array_start),
  .array_kind(array_kind), .array_addr(array_addr));
`default_nettype wire

//--- verification/fphc_spi_master.sv
// serial bus master model driving the flash control pins
`default_nettype none
module fphc_spi_master (
  input wire logic clk,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  output logic select_n,
  output logic sclk,
  output logic serial_in,
  output logic pause_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // bits seen on serial_out, an unknown wherever the output was released
  logic [39:0] rx = 40'h0;
  initial begin
    select_n = 1'h1;
    sclk = 1'h0;
    serial_in = 1'h0;
    pause_n = 1'h1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // clock stands still between frames; data flips once released
  task automatic frame(input logic [39:0] d, input int n, input int p,
                       input bit ab);
    select_n <= 1'h0;
    tick(6);
    for (int i = n - 1; i >= 0; i--) begin
      serial_in <= d[i];
      tick(4);
      sclk <= 1'h1;
      tick(4);
      // late sample: the output moves several clocks after each fall
      rx <= {rx[38:0], serial_out_oe ? serial_out : 1'hX};
      sclk <= 1'h0;
      if (i == p) begin
        tick(2);
        pause_n <= 1'h0;
        tick(12);
        sclk <= 1'h1; // a stray edge the paused device must ignore
        serial_in <= ~serial_in;
        tick(5);
        sclk <= 1'h0;
        tick(12);
        if (ab) begin
          select_n <= 1'h1;
          tick(10);
          pause_n <= 1'h1;
          tick(12);
          return;
        end
        pause_n <= 1'h1;
        tick(10);
      end
    end
    tick(5);
    select_n <= 1'h1;
    serial_in <= ~serial_in;
    tick(12);
  endtask
endmodule // fphc_spi_master
`default_nettype wire

//--- verification/tb_fphc_flash_protect_ctrl.sv
// self-checking bench for the flash protect control block
`default_nettype none
module tb_fphc_flash_protect_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [39:0] d; int n; logic [7:0] sw; logic [1:0] pm;
    logic [1:0] k; logic [18:0] a;} fphc_row_t;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic write_guard_n = 1'h1;
  wire select_n, sclk, serial_in, pause_n, serial_out, serial_out_oe;
  wire pause_active, array_start;
  wire [1:0] power_mode, array_kind;
  wire [7:0] status_word;
  wire [18:0] array_addr;
  logic [1:0] got_kind = 2'h0;
  logic [18:0] got_addr = 19'h0;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  // frame, expected status, mode, launch kind and address
  fphc_row_t rows [19] = '{
    '{40'h06, 8, 8'h02, 2'h0, 2'h0, 19'h0},
    '{40'h04, 8, 8'h00, 2'h0, 2'h0, 19'h0},
    '{40'h010C, 16, 8'h00, 2'h0, 2'h0, 19'h0},
    '{40'h06, 8, 8'h02, 2'h0, 2'h0, 19'h0},
    '{40'h010C, 16, 8'h0C, 2'h0, 2'h0, 19'h0},
    '{40'h06, 8, 8'h0E, 2'h0, 2'h0, 19'h0},
    '{40'hD8050000, 32, 8'h0E, 2'h0, 2'h0, 19'h0},
    '{40'hD8012345, 32, 8'h0C, 2'h0, 2'h2, 19'h12345},
    '{40'h06, 8, 8'h0E, 2'h0, 2'h0, 19'h0},
    '{40'hC7, 8, 8'h0E, 2'h0, 2'h0, 19'h0},
    '{40'h02030000AA, 40, 8'h0C, 2'h0, 2'h1, 19'h30000},
    '{40'h06, 8, 8'h0E, 2'h0, 2'h0, 19'h0},
    '{40'h0100, 15, 8'h0E, 2'h0, 2'h0, 19'h0},
    '{40'h0100, 16, 8'h00, 2'h0, 2'h0, 19'h0},
    '{40'h06, 8, 8'h02, 2'h0, 2'h0, 19'h0},
    '{40'hC7, 8, 8'h00, 2'h0, 2'h3, 19'h0},
    '{40'hB9, 8, 8'h00, 2'h2, 2'h0, 19'h0},
    '{40'h06, 8, 8'h00, 2'h2, 2'h0, 19'h0},
    '{40'hAB, 8, 8'h00, 2'h0, 2'h0, 19'h0}};
  fphc_flash_protect_ctrl #(.STATUS_CYCLES(4), .PAGE_CYCLES(4),
    .SECTOR_CYCLES(4), .BULK_CYCLES(4)) fphc_flash_protect_ctrl_i (
    .clk(clk), .rst(rst), .select_n(select_n), .sclk(sclk),
    .serial_in(serial_in), .pause_n(pause_n), .write_guard_n(write_guard_n),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .power_mode(power_mode), .status_word(status_word),
    .pause_active(pause_active), .array_start(array_start),
    .array_kind(array_kind), .array_addr(array_addr));
  fphc_spi_master fphc_spi_master_i (.clk(clk), .serial_out(serial_out),
    .serial_out_oe(serial_out_oe), .select_n(select_n),
    .sclk(sclk), .serial_in(serial_in), .pause_n(pause_n));
  always #5 clk = ~clk;
  task automatic check(input string what, input logic [39:0] seen,
                       input logic [39:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // one frame, then a bounded wait for the internal cycle to end
  task automatic run(input logic [39:0] d, input int n, input int p = -1,
                     input bit ab = 1'b0);
    fphc_spi_master_i.frame(d, n, p, ab);
    for (int i = 0; i < 300 && status_word[0] !== 1'h0; i++) @(posedge clk);
    repeat (3) @(posedge clk);
  endtask
  // launch monitor and hang limit
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (array_start === 1'h1) begin
      got_kind <= array_kind;
      got_addr <= array_addr;
    end else if (select_n === 1'h0) begin
      got_kind <= 2'h0; // forget the last launch once a new frame opens
    end
    // about five times the length of a clean run
    if (cycles == 20000) begin
      n_errors++;
      test_done();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    check("reset", {power_mode, pause_active, status_word}, 11'h0);
    rst <= 1'h0;
    repeat (6) @(posedge clk);
    foreach (rows[i]) begin
      run(rows[i].d, rows[i].n);
      check("status", status_word, rows[i].sw);
      check("mode", power_mode, rows[i].pm);
      check("kind", got_kind, rows[i].k);
      if (rows[i].k == 2'h1 || rows[i].k == 2'h2)
        check("addr", got_addr, rows[i].a);
      $display("row %0d done", i);
    end
    // lock bit with the guard pin low freezes the protection bits
    run(40'h06, 8);
    run(40'h018C, 16);
    check("lock", status_word, 8'h8C);
    write_guard_n <= 1'h0;
    run(40'h06, 8);
    run(40'h0100, 16);
    check("frozen", status_word[7:2], 6'h23);
    run(40'h0500, 16);
    check("read", fphc_spi_master_i.rx[7:0], 8'h8E);
    write_guard_n <= 1'h1;
    run(40'h06, 8);
    run(40'h0100, 16);
    check("freed", status_word, 8'h00);
    $display("guard test done");
    // pause mid-frame keeps the bits; deselect while paused drops it
    run(40'h06, 8, 3);
    check("paused", status_word, 8'h02);
    run(40'h0500, 16, 3);
    check("read paused", fphc_spi_master_i.rx[7:0], 8'h02);
    run(40'h04, 8, 3, 1'b1);
    check("aborted", {pause_active, status_word}, 9'h002);
    run(40'h04, 8);
    check("resumed", status_word, 8'h00);
    $display("pause test done");
    // reset in mid-run drops the latch; the link works again after it
    run(40'h06, 8);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    check("reset2", {power_mode, pause_active, status_word}, 11'h0);
    rst <= 1'h0;
    repeat (6) @(posedge clk);
    run(40'h06, 8);
    check("after reset", status_word, 8'h02);
    $display("reset test done");
    test_done();
  end
endmodule // tb_fphc_flash_protect_ctrl
`default_nettype wire
